// ===== thread_ctx_exc_regs.vh
/*
  constants of the thread context and exception controller: sizes, register
  offsets, field positions, reset values, exception codes and states.
  assumes it is included by bare name from the design files.
*/
`ifndef THREAD_CTX_EXC_REGS_VH
`define THREAD_CTX_EXC_REGS_VH

// ----------------------------------------
// sizes
// ----------------------------------------
`define NUM_TC 4
`define TC_W 2
`define NUM_VPE 2
`define IDX_W 6
`define MEM_W 8
`define AW 8

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTX0 8'h00
`define OFF_CTX1 8'h04
`define OFF_CTX2 8'h08
`define OFF_CTX3 8'h0c
`define OFF_PECTL 8'h20
`define OFF_PESTAT 8'h24
`define OFF_SHADOW 8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define B_ACT 0
`define B_DYN 1
`define B_HALT 2
`define B_PARK 3
`define B_EXEMPT 4
`define B_BLK 8
`define B_SUSP 9
`define B_ELIG 10
`define F_CODE 2:0
`define B_REL_INT 8
`define B_GS_INT 9
`define F_EXL 1:0
`define F_ERL 3:2
`define B_DBG 4
`define F_PSS 3:0
`define F_KSU 4:3

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_ACT 4'h1
`define RST_HALT 4'he
`define RST_DYN 4'h0
`define RST_ZERO4 4'h0
`define KSU_KERNEL 2'h0

// ----------------------------------------
// context state word indices
// ----------------------------------------
`define IDX_STATUS 6'h23

// ----------------------------------------
// thread exception codes and priorities
// ----------------------------------------
`define EXC_OVERFLOW 3'h0
`define EXC_UNDERFLOW 3'h1
`define EXC_BAD_QUAL 3'h2
`define EXC_GS_HELP 3'h3
`define EXC_REL_SCHED 3'h4
`define EXC_GS_SCHED 3'h5
`define PRIO_DEBUG 4'h0
`define PRIO_ASYNC 4'h4
`define PRIO_THREAD 4'h9
`define PRIO_NONE 4'hf

// ----------------------------------------
// controller states and bus answers
// ----------------------------------------
`define ST_IDLE 3'h1
`define ST_QUIESCE 3'h2
`define ST_HANDLER 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== issue_rr_arbiter.v
/*
  round-robin issue arbiter over the eligible thread contexts.
  assumes req is already stripped of blocked, suspended, halted and parked
  contexts; one grant per cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "thread_ctx_exc_regs.vh"

module issue_rr_arbiter (
  input wire aclk,
  input wire aresetn,
  input wire [`NUM_TC-1:0] req,
  output reg [`NUM_TC-1:0] grant
);

  reg [`TC_W-1:0] ptr;
  reg [`TC_W-1:0] idx;
  reg [`TC_W-1:0] gidx;
  reg found;
  integer i;

  // ----------------------------------------
  // search from the context after the last grant
  // ----------------------------------------
  always @* begin
    grant = {`NUM_TC{1'b0}};
    found = 1'b0;
    gidx = ptr;
    idx = ptr;
    for (i = 1; i <= `NUM_TC; i = i + 1) begin
      idx = ptr + i[`TC_W-1:0];
      if (!found && req[idx]) begin
        grant[idx] = 1'b1;
        gidx = idx;
        found = 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= {`TC_W{1'b0}};
    end else if (found) begin
      ptr <= gidx;
    end
  end

endmodule
`default_nettype wire

// ===== thread_ctx_exc_ctrl.v
/*
  thread context allocation, run state and exception control for a
  two virtual_pe core with two thread contexts each, with an axi4-lite slave.
  assumes the pipeline reports blocking, wake-up and exception conditions at
  its commit point on aclk and drains on its own when fetch is withdrawn.
*/
`timescale 1ns/10ps
`default_nettype none
`include "thread_ctx_exc_regs.vh"

module thread_ctx_exc_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [`AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire debug_mode,
  input wire spawn_req,
  output reg spawn_done,
  output reg [`TC_W-1:0] spawn_tc,
  input wire release_req,
  input wire [`TC_W-1:0] release_tc,
  input wire release_qual_ok,
  input wire release_free,
  input wire [`NUM_TC-1:0] sync_block,
  input wire [`NUM_TC-1:0] gs_block,
  input wire [`NUM_TC-1:0] gs_help,
  input wire [`NUM_TC-1:0] sync_wake,
  input wire [`NUM_TC-1:0] exc_req,
  input wire [4*`NUM_TC-1:0] exc_prio,
  input wire [`NUM_TC-1:0] exc_dbg,
  input wire [`NUM_VPE-1:0] async_req,
  input wire pipe_quiet,
  output wire [`NUM_TC-1:0] fetch_en,
  output wire [`NUM_TC-1:0] issue_grant,
  output wire [`NUM_TC-1:0] ctx_stable,
  output wire [`NUM_TC-1:0] ctx_suspended,
  output reg exc_taken,
  output reg [`TC_W-1:0] exc_tc,
  output reg exc_thread,
  output reg exc_use_shadow,
  output reg handler_start,
  output reg [`NUM_TC-1:0] replay,
  input wire ctx_wr_en,
  input wire [`TC_W-1:0] ctx_wr_tc,
  input wire [`IDX_W-1:0] ctx_wr_idx,
  input wire [31:0] ctx_wr_data,
  output wire ctx_wr_ready,
  input wire mv_req,
  input wire mv_write,
  input wire mv_prev,
  input wire [`TC_W-1:0] mv_src_tc,
  input wire [`TC_W-1:0] mv_tgt_tc,
  input wire [`IDX_W-1:0] mv_idx,
  input wire [31:0] mv_wdata,
  output reg mv_done,
  output reg mv_fault,
  output reg [31:0] mv_rdata
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [`TC_W:0] first_set;
    input [`NUM_TC-1:0] v;
    integer k;
    begin
      first_set = {(`TC_W+1){1'b0}};
      for (k = `NUM_TC - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = {1'b1, k[`TC_W-1:0]};
        end
      end
    end
  endfunction

  function vpe_of;
    input [`TC_W-1:0] t;
    begin
      vpe_of = t[`TC_W-1];
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [`NUM_TC-1:0] act, dyn, halt, park, exempt, blk;
  reg [`NUM_VPE-1:0] exception_level_bit, error_level_bit;
  reg dbg;
  reg [2:0] thr_code;
  reg rel_int, gs_int;
  reg [3:0] previous_shadow_set;
  reg [2:0] state;
  reg [`TC_W-1:0] owner;
  reg [`NUM_TC-1:0] thr_pend;
  reg [2:0] thr_pcode [0:`NUM_TC-1];
  reg [31:0] ctx_mem [0:(1<<`MEM_W)-1];
  wire [`NUM_TC-1:0] susp;
  wire [`NUM_TC-1:0] elig;
  localparam [`NUM_TC-1:0] boot_act = `RST_ACT;
  localparam [`NUM_TC-1:0] boot_halt = `RST_HALT;
  localparam [`NUM_TC-1:0] boot_dyn = `RST_DYN;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  reg aw_full, w_full;
  reg [`AW-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_go = aw_full && w_full && !s_axi_bvalid;
  wire wr_low = wr_go && w_strb[0];
  wire wr_mid = wr_go && w_strb[1];
  wire [3:0] ctx_hit;
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;

  genvar g;
  generate
    for (g = 0; g < `NUM_TC; g = g + 1) begin : dec
      assign ctx_hit[g] = aw_addr == (`OFF_CTX0 + g * 4);
    end
  endgenerate

  wire wr_map = (|ctx_hit) || aw_addr == `OFF_PECTL || aw_addr == `OFF_PESTAT ||
                aw_addr == `OFF_SHADOW;
  wire [`TC_W-1:0] rd_tc = s_axi_araddr[`TC_W+1:2];
  // only the four aligned context words and the pectl, pestat and shadow words decode; anything else answers an error
  wire rd_ctx = s_axi_araddr == `OFF_CTX0 || s_axi_araddr == `OFF_CTX1 ||
                s_axi_araddr == `OFF_CTX2 || s_axi_araddr == `OFF_CTX3;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= {`AW{1'b0}};
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h0;
        if (rd_ctx) begin
          s_axi_rdata[`B_ACT] <= act[rd_tc];
          s_axi_rdata[`B_DYN] <= dyn[rd_tc];
          s_axi_rdata[`B_HALT] <= halt[rd_tc];
          s_axi_rdata[`B_PARK] <= park[rd_tc];
          s_axi_rdata[`B_EXEMPT] <= exempt[rd_tc];
          s_axi_rdata[`B_BLK] <= blk[rd_tc];
          s_axi_rdata[`B_SUSP] <= susp[rd_tc];
          s_axi_rdata[`B_ELIG] <= elig[rd_tc];
        end else if (s_axi_araddr == `OFF_PECTL) begin
          s_axi_rdata[`F_CODE] <= thr_code;
          s_axi_rdata[`B_REL_INT] <= rel_int;
          s_axi_rdata[`B_GS_INT] <= gs_int;
        end else if (s_axi_araddr == `OFF_PESTAT) begin
          s_axi_rdata[`F_EXL] <= exception_level_bit;
          s_axi_rdata[`F_ERL] <= error_level_bit;
          s_axi_rdata[`B_DBG] <= dbg;
        end else if (s_axi_araddr == `OFF_SHADOW) begin
          s_axi_rdata[`F_PSS] <= previous_shadow_set;
        end else begin
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // eligibility and issue
  // ----------------------------------------
  wire quiesce = state == `ST_QUIESCE;
  generate
    for (g = 0; g < `NUM_TC; g = g + 1) begin : run
      assign susp[g] = act[g] && (owner != g || state == `ST_IDLE) &&
                       (dbg || exception_level_bit[vpe_of(g)] || error_level_bit[vpe_of(g)]);
      assign elig[g] = act[g] && !blk[g] && !halt[g] && !susp[g] && !park[g];
    end
  endgenerate
  assign fetch_en = quiesce ? {`NUM_TC{1'b0}} : elig;
  assign ctx_stable = halt;
  assign ctx_suspended = susp;

  issue_rr_arbiter arb (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(fetch_en),
    .grant(issue_grant)
  );

  // ----------------------------------------
  // spawn and release
  // ----------------------------------------
  // spawn candidate
  wire [`TC_W:0] spawn_pick = first_set(~act & dyn & ~halt);
  wire [`TC_W:0] async_pick0 = first_set(elig & ~exempt & 4'h3);
  wire [`TC_W:0] async_pick1 = first_set(elig & ~exempt & 4'hc);
  wire rel_ok = release_req && release_qual_ok && !susp[release_tc];
  wire [`NUM_TC-1:0] rel_vmask = vpe_of(release_tc) ? 4'hc : 4'h3;
  wire [`NUM_TC-1:0] rel_bit = 4'h1 << release_tc;
  wire underflow = rel_ok && release_free && dyn[release_tc] &&
                   ((act & dyn & rel_vmask & ~rel_bit) == 4'h0);
  wire rel_trap = rel_ok && !release_free && rel_int;
  // release changes allocation only of dyn_alloc
  wire rel_dealloc = rel_ok && release_free && dyn[release_tc] && !underflow;
  wire rel_wait = rel_ok && !release_free && !rel_int;
  wire spawn_ok = spawn_req && spawn_pick[`TC_W];

  // ----------------------------------------
  // per-context control bits
  // ----------------------------------------
  reg [`NUM_TC-1:0] next_thr_pend;
  reg [2:0] next_pcode [0:`NUM_TC-1];
  generate
    for (g = 0; g < `NUM_TC; g = g + 1) begin : ctl
      wire sw = wr_low && ctx_hit[g];
      wire spawn_here = spawn_ok && spawn_pick[`TC_W-1:0] == g;
      wire rel_here = release_tc == g;
      always @(posedge aclk) begin
        if (!aresetn) begin
          act[g] <= boot_act[g];
          halt[g] <= boot_halt[g];
          dyn[g] <= boot_dyn[g];
          park[g] <= 1'b0;
          exempt[g] <= 1'b0;
          blk[g] <= 1'b0;
        end else begin
          if (spawn_here) begin
            act[g] <= 1'b1;
          end else if (rel_dealloc && rel_here) begin
            act[g] <= 1'b0;
          end else if (sw) begin
            act[g] <= w_data[`B_ACT];
          end
          if (sw) begin
            dyn[g] <= w_data[`B_DYN];
            halt[g] <= w_data[`B_HALT];
            exempt[g] <= w_data[`B_EXEMPT];
          end
          if (sw && debug_mode) begin
            park[g] <= w_data[`B_PARK];
          end
          if (sync_block[g] || (gs_block[g] && !gs_int) || (rel_wait && rel_here)) begin
            blk[g] <= 1'b1;
          end else if (sync_wake[g] || (spawn_here)) begin
            blk[g] <= 1'b0;
          end
        end
      end
      always @* begin
        next_thr_pend[g] = thr_pend[g];
        next_pcode[g] = thr_pcode[g];
        if (exc_taken && exc_tc == g && exc_thread) begin
          next_thr_pend[g] = 1'b0;
        end
        if (!susp[g]) begin
          if (spawn_req && !spawn_pick[`TC_W] && issue_grant[g]) begin
            next_thr_pend[g] = 1'b1;
            next_pcode[g] = `EXC_OVERFLOW;
          end else if (release_req && rel_here && !release_qual_ok) begin
            next_thr_pend[g] = 1'b1;
            next_pcode[g] = `EXC_BAD_QUAL;
          end else if (underflow && rel_here) begin
            next_thr_pend[g] = 1'b1;
            next_pcode[g] = `EXC_UNDERFLOW;
          end else if (rel_trap && rel_here) begin
            next_thr_pend[g] = 1'b1;
            next_pcode[g] = `EXC_REL_SCHED;
          end else if (gs_block[g] && gs_int) begin
            next_thr_pend[g] = 1'b1;
            next_pcode[g] = `EXC_GS_SCHED;
          end else if (gs_help[g]) begin
            next_thr_pend[g] = 1'b1;
            next_pcode[g] = `EXC_GS_HELP;
          end
        end
      end
      always @(posedge aclk) begin
        if (!aresetn) begin
          thr_pend[g] <= 1'b0;
          thr_pcode[g] <= `EXC_OVERFLOW;
        end else begin
          thr_pend[g] <= next_thr_pend[g];
          thr_pcode[g] <= next_pcode[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // exception arbitration
  // ----------------------------------------
  reg [3:0] best_pr, pr;
  reg [`TC_W-1:0] best_tc;
  reg best_thr, best_dbg;
  reg [`NUM_TC-1:0] cand;
  integer t;
  always @* begin
    best_pr = `PRIO_NONE;
    best_tc = {`TC_W{1'b0}};
    best_thr = 1'b0;
    best_dbg = 1'b0;
    cand = {`NUM_TC{1'b0}};
    pr = `PRIO_NONE;
    for (t = 0; t < `NUM_TC; t = t + 1) begin
      pr = `PRIO_NONE;
      if (exc_dbg[t] && !dbg) begin
        pr = `PRIO_DEBUG;
      end else if (exc_req[t]) begin
        pr = exc_prio[4*t +: 4];
      end else if ((async_req[0] && async_pick0[`TC_W] && async_pick0[`TC_W-1:0] == t) ||
                   (async_req[1] && async_pick1[`TC_W] && async_pick1[`TC_W-1:0] == t)) begin
        pr = `PRIO_ASYNC;
      end else if (thr_pend[t]) begin
        pr = `PRIO_THREAD;
      end
      if (!act[t] || susp[t] || (pr != `PRIO_DEBUG && (dbg || exception_level_bit[vpe_of(t[`TC_W-1:0])] ||
          error_level_bit[vpe_of(t[`TC_W-1:0])]))) begin
        pr = `PRIO_NONE;
      end
      cand[t] = pr != `PRIO_NONE;
      if (pr < best_pr) begin
        best_pr = pr;
        best_tc = t[`TC_W-1:0];
        best_thr = pr == `PRIO_THREAD;
        best_dbg = pr == `PRIO_DEBUG;
      end
    end
  end
  wire take = state == `ST_IDLE && best_pr != `PRIO_NONE;

  // ----------------------------------------
  // exception sequence
  // ----------------------------------------
  reg [2:0] next_state;
  wire level_clear = !dbg && !exception_level_bit[vpe_of(owner)] && !error_level_bit[vpe_of(owner)];
  always @* begin
    case (state)
      `ST_IDLE: next_state = take ? `ST_QUIESCE : `ST_IDLE;
      `ST_QUIESCE: next_state = pipe_quiet ? `ST_HANDLER : `ST_QUIESCE;
      `ST_HANDLER: next_state = level_clear ? `ST_IDLE : `ST_HANDLER;
      default: next_state = `ST_IDLE;
    endcase
  end

  wire [`NUM_TC-1:0] best_bit = 4'h1 << best_tc;
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= `ST_IDLE;
      owner <= {`TC_W{1'b0}};
      exception_level_bit <= {`NUM_VPE{1'b0}};
      error_level_bit <= {`NUM_VPE{1'b0}};
      dbg <= 1'b0;
      thr_code <= `EXC_OVERFLOW;
      rel_int <= 1'b0;
      gs_int <= 1'b0;
      previous_shadow_set <= `RST_ZERO4;
      exc_taken <= 1'b0;
      exc_tc <= {`TC_W{1'b0}};
      exc_thread <= 1'b0;
      exc_use_shadow <= 1'b0;
      handler_start <= 1'b0;
      replay <= {`NUM_TC{1'b0}};
      spawn_done <= 1'b0;
      spawn_tc <= {`TC_W{1'b0}};
    end else begin
      state <= next_state;
      exc_taken <= take;
      handler_start <= state == `ST_QUIESCE && pipe_quiet;
      replay <= take ? (cand & ~best_bit) : {`NUM_TC{1'b0}};
      spawn_done <= spawn_ok;
      if (spawn_ok) begin
        spawn_tc <= spawn_pick[`TC_W-1:0];
      end
      // intercept bits sit in byte 1, so only that strobe may change them
      if (wr_mid && aw_addr == `OFF_PECTL) begin
        rel_int <= w_data[`B_REL_INT];
        gs_int <= w_data[`B_GS_INT];
      end
      if (wr_low && aw_addr == `OFF_SHADOW) begin
        previous_shadow_set <= w_data[`F_PSS];
      end
      // level bits: hardware set wins over software write
      if (wr_low && aw_addr == `OFF_PESTAT) begin
        exception_level_bit <= w_data[`F_EXL];
        error_level_bit <= w_data[`F_ERL];
        dbg <= w_data[`B_DBG];
      end
      if (take) begin
        owner <= best_tc;
        exc_tc <= best_tc;
        exc_thread <= best_thr;
        exc_use_shadow <= previous_shadow_set != `RST_ZERO4;
        if (best_dbg) begin
          dbg <= 1'b1;
        end else begin
          exception_level_bit[vpe_of(best_tc)] <= 1'b1;
        end
        if (best_thr) begin
          thr_code <= thr_pcode[best_tc];
        end
      end
    end
  end

  // ----------------------------------------
  // context state and target moves
  // ----------------------------------------
  wire [31:0] src_status = ctx_mem[{mv_src_tc, `IDX_STATUS}];
  wire mv_priv = src_status[`F_KSU] == `KSU_KERNEL || exception_level_bit[vpe_of(mv_src_tc)] || debug_mode;
  wire [`TC_W-1:0] mv_tc = (mv_prev && previous_shadow_set == `RST_ZERO4) ? owner : mv_tgt_tc;
  wire mv_wr = mv_req && mv_write && mv_priv && !susp[mv_src_tc];
  assign ctx_wr_ready = !mv_wr;

  always @(posedge aclk) begin
    if (mv_wr) begin
      ctx_mem[{mv_tc, mv_idx}] <= mv_wdata;
    end else if (ctx_wr_en) begin
      ctx_mem[{ctx_wr_tc, ctx_wr_idx}] <= ctx_wr_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      mv_done <= 1'b0;
      mv_fault <= 1'b0;
      mv_rdata <= 32'h0;
    end else begin
      mv_done <= mv_req;
      mv_fault <= mv_req && !mv_priv;
      if (mv_req && !mv_write && mv_priv) begin
        mv_rdata <= ctx_mem[{mv_tc, mv_idx}];
      end
    end
  end

endmodule
`default_nettype wire

// ===== tce_props.sv
/* port checker of the thread context controller.
   assumes it is bound onto the controller top. */
`timescale 1ns/10ps
`default_nettype none
module tce_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] fetch_en,
  input wire logic [3:0] issue_grant,
  input wire logic [3:0] ctx_stable,
  input wire logic [3:0] ctx_suspended,
  input wire logic [3:0] replay,
  input wire logic exc_taken,
  input wire logic handler_start,
  input wire logic pipe_quiet,
  input wire logic spawn_req,
  input wire logic spawn_done,
  input wire logic mv_req,
  input wire logic mv_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  halt_fetch_a: assert property ((fetch_en & ctx_stable) == 4'h0)
    else $error("halted context fetches");
  susp_fetch_a: assert property ((fetch_en & ctx_suspended) == 4'h0)
    else $error("suspended context fetches");
  grant_elig_a: assert property ($onehot0(issue_grant) && (issue_grant & ~fetch_en) == 4'h0)
    else $error("grant outside eligible set");
  boot_ctx_a: assert property ($rose(aresetn) |-> fetch_en == 4'h1)
    else $error("wrong boot context");
  spawn_ans_a: assert property (spawn_done |-> $past(spawn_req))
    else $error("spawn answer without request");
  quiesce_fetch_a: assert property (exc_taken |-> fetch_en == 4'h0)
    else $error("fetch during quiesce");
  handler_wait_a: assert property (handler_start |-> $past(pipe_quiet) && !exc_taken)
    else $error("handler before quiet");
  one_exc_a: assert property (exc_taken |=> !exc_taken [*2])
    else $error("second exception taken");
  replay_with_a: assert property (replay != 4'h0 |-> exc_taken)
    else $error("replay without exception");
  move_ans_a: assert property (mv_done |-> $past(mv_req))
    else $error("move answer without request");
  cover property (exc_taken);
  cover property (handler_start);
  cover property (spawn_done);
endmodule
bind thread_ctx_exc_ctrl tce_props i_tce_props (.*);
`default_nettype wire

// ===== pipe_model.sv
/* pipeline drain model beside the controller.
   assumes exc_taken is a one-cycle pulse on aclk. */
`timescale 1ns/10ps
`default_nettype none
module pipe_model (
  input wire logic aclk,
  input wire logic exc_taken,
  input wire logic slow,
  output logic pipe_quiet
);
  int n = 0;
  always @(posedge aclk) begin
    if (exc_taken)
      n <= slow ? 6 : 1;
    else if (n != 0)
      n <= n - 1;
  end
  // quiet drops at once, so a slow drain is really seen
  assign pipe_quiet = (n == 0) && !exc_taken;
endmodule
`default_nettype wire

// ===== tb.sv
/* self-checking bench of the thread context controller.
   assumes the pipeline model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic aclk = 0, aresetn = 0, slow = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, ctx_wr_data = 0, mv_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf, sync_block = 0, gs_block = 0, gs_help = 0;
  logic [3:0] sync_wake = 0, exc_req = 0, exc_dbg = 0;
  logic [15:0] exc_prio = 16'hffff;
  logic [1:0] async_req = 0, release_tc = 0, ctx_wr_tc = 0, mv_src_tc = 0, mv_tgt_tc = 0;
  logic [5:0] ctx_wr_idx = 0, mv_idx = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, debug_mode = 0, spawn_req = 0, release_req = 0;
  logic release_free = 0, release_qual_ok = 1, ctx_wr_en = 0;
  logic mv_req = 0, mv_write = 0, mv_prev = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire spawn_done, exc_taken, exc_thread, exc_use_shadow, handler_start;
  wire ctx_wr_ready, mv_done, mv_fault, pipe_quiet;
  wire [1:0] s_axi_bresp, s_axi_rresp, spawn_tc, exc_tc;
  wire [3:0] fetch_en, issue_grant, ctx_stable, ctx_suspended, replay;
  wire [31:0] s_axi_rdata, mv_rdata;
  int fails = 0, compares = 0, cyc = 0, i;
  thread_ctx_exc_ctrl i_thread_ctx_exc_ctrl (.*);
  pipe_model i_pipe_model (.*);
  initial forever #2.5 aclk = ~aclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    fork
      begin
        @(posedge aclk);
        while (!s_axi_awready) @(posedge aclk);
        s_axi_awvalid <= 0;
      end
      begin
        @(posedge aclk);
        while (!s_axi_wready) @(posedge aclk);
        s_axi_wvalid <= 0;
      end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 0;
    chk(s_axi_bresp, 2'h0);
    @(posedge aclk);
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 0;
    @(posedge aclk);
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask
  // bounded wait for a pulse; h picks handler start
  task wt(input bit h);
    i = 0;
    while ((h ? handler_start : exc_taken) !== 1'b1 && i < 40) begin
      @(posedge aclk);
      i++;
    end
    chk(i < 40, 1);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    tk(10);
    aresetn <= 1;
    tk(1);
    chk(fetch_en, 4'h1);
    chk(ctx_stable, 4'he);
    rd(8'h00, 32'h401, 2'h0);
    rd(8'h04, 32'h4, 2'h0);
    rd(8'h3c, 32'h0, 2'h2);
    wr(8'h00, 32'h9);
    rd(8'h00, 32'h401, 2'h0);
    debug_mode <= 1;
    wr(8'h00, 32'h9);
    chk(fetch_en, 4'h0);
    wr(8'h00, 32'h1);
    debug_mode <= 0;
    wr(8'h04, 32'h2);
    spawn_req <= 1;
    tk(1);
    spawn_req <= 0;
    tk(1);
    chk({spawn_done, spawn_tc}, 3'h5);
    chk(fetch_en, 4'h3);
    sync_block <= 4'h1;
    tk(1);
    sync_block <= 4'h0;
    tk(6);
    chk(fetch_en, 4'h2);
    sync_wake <= 4'h1;
    tk(1);
    sync_wake <= 4'h0;
    tk(1);
    chk(fetch_en, 4'h3);
    // pipeline fills context 0 status (kernel) and context 1 word 0
    ctx_wr_en <= 1;
    ctx_wr_idx <= 6'h23;
    tk(1);
    ctx_wr_tc <= 2'h1;
    ctx_wr_idx <= 6'h0;
    ctx_wr_data <= 32'h5a;
    tk(1);
    ctx_wr_en <= 0;
    mv_req <= 1;
    mv_tgt_tc <= 2'h1;
    tk(1);
    mv_req <= 0;
    tk(1);
    chk({mv_done, mv_fault}, 2'h2);
    chk(mv_rdata, 32'h5a);
    exc_prio <= 16'hff25;
    exc_req <= 4'h3;
    tk(1);
    exc_req <= 4'h0;
    tk(1);
    chk({exc_taken, exc_tc, exc_thread, exc_use_shadow}, 5'h14);
    chk(replay, 4'h1);
    chk(ctx_suspended, 4'h1);
    wt(1);
    wr(8'h24, 32'h0);
    slow <= 1;
    exc_prio <= 16'hffff;
    release_req <= 1;
    release_qual_ok <= 0;
    tk(1);
    release_req <= 0;
    release_qual_ok <= 1;
    wt(0);
    chk({exc_tc, exc_thread}, 3'h1);
    wt(1);
    rd(8'h20, 32'h2, 2'h0);
    rd(8'h24, 32'h1, 2'h0);
    wr(8'h24, 32'h0);
    // gating intercept turns a blocking access into a thread exception
    wr(8'h20, 32'h200);
    gs_block <= 4'h1;
    tk(1);
    gs_block <= 4'h0;
    wt(0);
    chk({exc_tc, exc_thread}, 3'h1);
    rd(8'h20, 32'h205, 2'h0);
    wr(8'h24, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
